/* File: verilog/ett_top.sv */
// Exposure trigger timer: start delay, exposure length and AXI4-Lite registers
`timescale 1ns/1ps
// How it works
// (R1) A hardware start edge waits the programmed delay in microseconds before exposure begins.
// (R2) With triggering off or with a software source, exposure starts with no delay.
// (R3) Fixed-length exposure lasts the multiplier times the tick length.
// (R4) Multiplier writes outside 1 to 4095 are rejected and the old value kept.
// (R5) Tick length resets to 20 us and is set in whole microseconds.
// (R6) Software keeps exposure between the part minimum and ten million microseconds.
// (R7) Multiplier one with tick length ten million gives the longest exposure.
// (R8) Auto exposure uses its own microsecond length, not bound to tick multiples.
// (R9) Auto exposure is forced off while pulse-length exposure is selected.
// (R10) With the rate limit off, the next frame waits only for the next start edge.
// (R11) After the arm command, the selected edge of the input starts acquisition.
// (R12) All delays and all but pulse-length exposures count a free-running one microsecond tick.
// (R13) Start edges outside the waiting phase are discarded.
// (R14) A start edge during exposure is ignored and raises an overtrigger event.
// (R15) Fixed-length exposure begins at the selected edge of the input.
// (R16) Pulse-length exposure runs from the selected edge until the opposite one.
module ett_top
	import ett_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire ett_axi_req_s axi_req,
	output ett_axi_rsp_s axi_rsp,
	// Trigger line
	input wire logic external_start_trigger_input,
	// Exposure status
	output logic exposure_active,
	output logic overtrigger_pulse,
	output logic frame_start_pulse,
	output logic waiting_for_trigger
);

	// ==========================================
	// Masked word write
	// Lanes whose strobe is low keep their old bytes
	function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : wmask

	ett_state_s s;
	ett_state_s n;
	logic cmd_arm;
	logic cmd_sw;
	logic cmd_stop;
	logic ovt_clr;
	logic go;
	logic fin;
	logic act_edge;
	logic act_level;
	logic [31:0] wv;
	logic [31:0] rv;
	logic [1:0] rr;

	// ==========================================
	// Next state
	always_comb begin
		n = s;
		cmd_arm = 1'b0;
		cmd_sw = 1'b0;
		cmd_stop = 1'b0;
		ovt_clr = 1'b0;
		go = 1'b0;
		fin = 1'b0;
		wv = 32'h00000000;
		rv = 32'h00000000;
		rr = 2'b00;
		n.ovt_pulse = 1'b0;
		n.frame_pulse = 1'b0;

		// Limitation: starts and ends carry up to one microsecond of jitter
		// Free-running microsecond tick
		if (s.div == 5'(`ETT_US_CYCLES - 1)) begin // R12
			n.div = 5'h00;
			n.us = 1'b1;
		end else begin
			n.div = s.div + 5'h01;
			n.us = 1'b0;
		end

		// Edge detect; the input is taken as synchronous
		// A false edge just after reset is harmless, since IDLE discards it
		n.trig_prev = external_start_trigger_input;
		act_level = ~s.ctrl[`ETT_CTRL_EDGE_FALL];
		act_edge = (external_start_trigger_input == act_level) &&
			(s.trig_prev != act_level) && s.ctrl[`ETT_CTRL_LINE_SRC] &&
			s.ctrl[`ETT_CTRL_TRIG_ON];

		// Write channel: address and data caught in either order
		// The response must be taken before another write is accepted
		if (s.rsp.bvalid && axi_req.bready) begin
			n.rsp.bvalid = 1'b0;
		end
		if (s.aw_held && s.w_held && !s.rsp.bvalid) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.rsp.bvalid = 1'b1;
			n.rsp.bresp = 2'b00;
			case (s.awaddr)
				`ETT_OFF_CTRL: begin
					wv = wmask({26'h0, s.ctrl}, s.wdata, s.wstrb);
					n.ctrl = wv[`ETT_CTRL_W-1:0];
				end
				`ETT_OFF_CMD: begin
					wv = wmask(32'h00000000, s.wdata, s.wstrb);
					cmd_arm = wv[`ETT_CMD_ARM]; // R11
					cmd_sw = wv[`ETT_CMD_SWTRIG];
					cmd_stop = wv[`ETT_CMD_STOP];
				end
				`ETT_OFF_MULT: begin
					wv = wmask({20'h0, s.mult}, s.wdata, s.wstrb);
					if (wv[31:12] == 20'h00000 && wv[11:0] != 12'h000) begin // R4
						n.mult = wv[11:0];
					end
				end
				`ETT_OFF_TICK: begin
					wv = wmask({8'h0, s.tick_len}, s.wdata, s.wstrb);
					if (wv[31:24] == 8'h00 && wv[23:0] != 24'h000000) begin // R5
						n.tick_len = wv[23:0];
					end
				end
				`ETT_OFF_DELAY: begin
					wv = wmask({8'h0, s.delay_us}, s.wdata, s.wstrb);
					n.delay_us = wv[23:0];
				end
				`ETT_OFF_AUTO: begin
					wv = wmask({8'h0, s.auto_us}, s.wdata, s.wstrb);
					if (wv[23:0] != 24'h000000) begin // R8
						n.auto_us = wv[23:0];
					end
				end
				`ETT_OFF_STATUS: begin
					wv = wmask(32'h00000000, s.wdata, s.wstrb);
					ovt_clr = wv[`ETT_ST_OVT];
				end
				`ETT_OFF_RATE: begin
					wv = wmask({8'h0, s.rate_us}, s.wdata, s.wstrb);
					n.rate_us = wv[23:0];
				end
				default: begin
					n.rsp.bresp = 2'b10;
				end
			endcase
		end
		if (axi_req.awvalid && s.rsp.awready) begin
			n.aw_held = 1'b1;
			n.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && s.rsp.wready) begin
			n.w_held = 1'b1;
			n.wdata = axi_req.wdata;
			n.wstrb = axi_req.wstrb;
		end

		// Auto exposure cannot coexist with pulse-length exposure
		if (n.ctrl[`ETT_CTRL_PULSE]) begin
			n.ctrl[`ETT_CTRL_AUTO] = 1'b0; // R9
		end

		// Read channel
		// Data captured at the address handshake, so it cannot move while rvalid stands
		if (s.rsp.rvalid && axi_req.rready) begin
			n.rsp.rvalid = 1'b0;
		end
		case (axi_req.araddr)
			`ETT_OFF_CTRL: rv = {26'h0, s.ctrl};
			`ETT_OFF_CMD: rv = 32'h00000000;
			`ETT_OFF_MULT: rv = {20'h0, s.mult};
			`ETT_OFF_TICK: rv = {8'h0, s.tick_len};
			`ETT_OFF_DELAY: rv = {8'h0, s.delay_us};
			`ETT_OFF_AUTO: rv = {8'h0, s.auto_us};
			`ETT_OFF_STATUS: begin
				rv[`ETT_ST_WAIT] = s.waiting;
				rv[`ETT_ST_DELAY] = (s.phase == ETT_DELAY);
				rv[`ETT_ST_EXPOSE] = s.expose;
				rv[`ETT_ST_OVT] = s.ovt_sticky;
				rv[`ETT_ST_ARMED] = (s.phase != ETT_IDLE);
			end
			`ETT_OFF_RATE: rv = {8'h0, s.rate_us};
			default: rr = 2'b10;
		endcase
		if (axi_req.arvalid && s.rsp.arready) begin
			n.rsp.rvalid = 1'b1;
			n.rsp.rdata = rv;
			n.rsp.rresp = rr;
		end

		// Acquisition sequencer
		case (s.phase)
			ETT_IDLE: begin
				if (cmd_arm) begin // R11
					n.phase = ETT_WAIT;
				end
			end
			ETT_WAIT: begin
				// Triggering off means free run: with the rate limit off, each exposure follows the last at once
				if (!s.ctrl[`ETT_CTRL_TRIG_ON]) begin
					go = 1'b1; // R2
				end else if (!s.ctrl[`ETT_CTRL_LINE_SRC]) begin
					go = cmd_sw; // R2
				end else if (act_edge) begin // R15
					if (s.delay_us == 24'h000000) begin
						go = 1'b1;
					end else begin
						n.phase = ETT_DELAY; // R1
						n.cnt = 24'h000000;
					end
				end
			end
			ETT_DELAY: begin
				// Edges while delaying fall away unseen
				if (s.us) begin // R13
					if (s.cnt == s.delay_us - 24'h000001) begin // R1
						go = 1'b1;
					end else begin
						n.cnt = s.cnt + 24'h000001;
					end
				end
			end
			ETT_EXPOSE: begin
				if (act_edge) begin // R14
					n.ovt_pulse = 1'b1;
				end
				if (s.pulse_ex) begin
					// Level test also ends an exposure whose release came during the delay
					if (external_start_trigger_input != act_level) begin // R16
						fin = 1'b1;
					end
				end else if (s.us) begin // R3
					// Tick length repeats mult times; the counter restarts each pass
					if (s.cnt == s.len - 24'h000001) begin
						n.cnt = 24'h000000;
						if (s.rep == 12'h001) begin // R7
							fin = 1'b1;
						end else begin
							n.rep = s.rep - 12'h001;
						end
					end else begin
						n.cnt = s.cnt + 24'h000001;
					end
				end
			end
			ETT_HOLD: begin
				// Hold-off paces frames only when the limit is on; zero length skips it
				if (s.rate_us == 24'h000000) begin
					n.phase = ETT_WAIT;
				end else if (s.us) begin
					if (s.cnt == s.rate_us - 24'h000001) begin
						n.phase = ETT_WAIT;
					end else begin
						n.cnt = s.cnt + 24'h000001;
					end
				end
			end
			default: begin
				n.phase = ETT_IDLE;
			end
		endcase

		// Exposure start: length latched so later writes do not stretch it
		if (go) begin
			n.phase = ETT_EXPOSE;
			n.expose = 1'b1;
			n.frame_pulse = 1'b1;
			n.cnt = 24'h000000;
			n.pulse_ex = s.ctrl[`ETT_CTRL_PULSE] && s.ctrl[`ETT_CTRL_TRIG_ON] &&
				s.ctrl[`ETT_CTRL_LINE_SRC];
			if (s.ctrl[`ETT_CTRL_AUTO]) begin // R8
				// Auto length stands alone; no tick multiple is forced on it
				n.len = s.auto_us;
				n.rep = 12'h001;
			end else begin // R3
				n.len = s.tick_len;
				n.rep = s.mult;
			end
		end

		// Exposure end: pace internally only when the limit is on
		if (fin) begin
			n.expose = 1'b0;
			n.cnt = 24'h000000;
			n.phase = s.ctrl[`ETT_CTRL_RATE_ON] ? ETT_HOLD : ETT_WAIT; // R10
		end

		// Stop wins over the sequencer and the frame pulse, aborting any exposure; an overtrigger pulse from the same cycle still fires
		// A start granted in the same cycle is dropped too, so no stray frame pulse
		if (cmd_stop) begin
			n.phase = ETT_IDLE;
			n.expose = 1'b0;
			n.frame_pulse = 1'b0;
			n.cnt = 24'h000000;
		end

		// Overtrigger flag: a new event beats a clear in the same cycle
		if (ovt_clr) begin
			n.ovt_sticky = 1'b0;
		end
		if (n.ovt_pulse) begin // R14
			n.ovt_sticky = 1'b1;
		end

		n.waiting = (n.phase == ETT_WAIT);
		n.rsp.awready = !n.aw_held && !n.rsp.bvalid;
		n.rsp.wready = !n.w_held && !n.rsp.bvalid;
		n.rsp.arready = !n.rsp.rvalid;
	end

	// ==========================================
	// State register
	// Only constants under reset; configuration returns to its defaults
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.phase <= ETT_IDLE;
			s.ctrl <= `ETT_RST_CTRL;
			s.mult <= `ETT_RST_MULT;
			s.tick_len <= `ETT_RST_TICK; // R5
			s.delay_us <= `ETT_RST_DELAY;
			s.auto_us <= `ETT_RST_AUTO;
			s.rate_us <= `ETT_RST_RATE;
		end else begin
			s <= n;
		end
	end

	// ==========================================
	// Outputs, all straight from the state register
	// No logic after the register, so every output is free of glitches
	assign axi_rsp = s.rsp;
	assign exposure_active = s.expose;
	assign overtrigger_pulse = s.ovt_pulse;
	assign frame_start_pulse = s.frame_pulse;
	assign waiting_for_trigger = s.waiting;

endmodule : ett_top

/* File: shared/ett_params.svh */
// Offsets, field positions, reset values and timing counts of the exposure trigger timer
`ifndef ETT_PARAMS_SVH
`define ETT_PARAMS_SVH
// ==========================================
// Bus geometry
`define ETT_ADDR_W 8
`define ETT_DATA_W 32
// ==========================================
// Register byte offsets
`define ETT_OFF_CTRL 8'h00
`define ETT_OFF_CMD 8'h04
`define ETT_OFF_MULT 8'h08
`define ETT_OFF_TICK 8'h0c
`define ETT_OFF_DELAY 8'h10
`define ETT_OFF_AUTO 8'h14
`define ETT_OFF_STATUS 8'h18
`define ETT_OFF_RATE 8'h1c
// ==========================================
// Control bits
`define ETT_CTRL_TRIG_ON 0
`define ETT_CTRL_LINE_SRC 1
`define ETT_CTRL_EDGE_FALL 2
`define ETT_CTRL_PULSE 3
`define ETT_CTRL_RATE_ON 4
`define ETT_CTRL_AUTO 5
`define ETT_CTRL_W 6
// Command bits
`define ETT_CMD_ARM 0
`define ETT_CMD_SWTRIG 1
`define ETT_CMD_STOP 2
// Status bits
`define ETT_ST_WAIT 0
`define ETT_ST_DELAY 1
`define ETT_ST_EXPOSE 2
`define ETT_ST_OVT 3
`define ETT_ST_ARMED 4
// ==========================================
// Reset values
`define ETT_RST_CTRL 6'h03
`define ETT_RST_MULT 12'h001
`define ETT_RST_TICK 24'h000014
`define ETT_RST_DELAY 24'h000000
`define ETT_RST_AUTO 24'h000014
`define ETT_RST_RATE 24'h000000
// ==========================================
// Timing: one microsecond tick from a 40 ns clock
`define ETT_TICK_NS 1000
`define ETT_CLK_PERIOD_NS 40
`define ETT_US_CYCLES (`ETT_TICK_NS / `ETT_CLK_PERIOD_NS)
`endif

/* File: shared/ett_pkg.sv */
// Types shared by the exposure trigger timer
`include "ett_params.svh"
package ett_pkg;
	// ==========================================
	// Sequencer phases
	typedef enum logic [2:0] {
		ETT_IDLE,
		ETT_WAIT,
		ETT_DELAY,
		ETT_EXPOSE,
		ETT_HOLD
	} ett_phase_e;

	// ==========================================
	// AXI4-Lite request from the master
	typedef struct packed {
		logic awvalid;
		logic [`ETT_ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [`ETT_DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [`ETT_ADDR_W-1:0] araddr;
		logic rready;
	} ett_axi_req_s;

	// AXI4-Lite response from the slave
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [`ETT_DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} ett_axi_rsp_s;

	// ==========================================
	// Whole state of the timer
	typedef struct packed {
		ett_phase_e phase;
		logic [`ETT_CTRL_W-1:0] ctrl;
		logic [11:0] mult;
		logic [23:0] tick_len;
		logic [23:0] delay_us;
		logic [23:0] auto_us;
		logic [23:0] rate_us;
		logic ovt_sticky;
		logic [4:0] div;
		logic us;
		logic [23:0] cnt;
		logic [23:0] len;
		logic [11:0] rep;
		logic pulse_ex;
		logic trig_prev;
		logic expose;
		logic ovt_pulse;
		logic frame_pulse;
		logic waiting;
		logic aw_held;
		logic [`ETT_ADDR_W-1:0] awaddr;
		logic w_held;
		logic [`ETT_DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		ett_axi_rsp_s rsp;
	} ett_state_s;
endpackage : ett_pkg

/* File: dv/ett_properties.sv */
// Port-level assertions for the exposure trigger timer
`timescale 1ns/1ps
module ett_properties
	import ett_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire ett_axi_req_s axi_req,
	input wire ett_axi_rsp_s axi_rsp,
	// Trigger and status
	input wire logic external_start_trigger_input,
	input wire logic exposure_active,
	input wire logic overtrigger_pulse,
	input wire logic frame_start_pulse,
	input wire logic waiting_for_trigger
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================
	// Exposure sequencing
	property p_fs_rise;
		$rose(exposure_active) |-> frame_start_pulse ##1 !frame_start_pulse;
	endproperty
	a_fs_rise: assert property (p_fs_rise) else $error("frame start wrong");
	property p_fs_exp;
		frame_start_pulse |-> exposure_active && !waiting_for_trigger;
	endproperty
	a_fs_exp: assert property (p_fs_exp) else $error("frame start outside exposure");
	property p_ovt;
		overtrigger_pulse |-> $past(exposure_active) ##1 !overtrigger_pulse;
	endproperty
	a_ovt: assert property (p_ovt) else $error("overtrigger outside exposure");
	property p_excl;
		!(waiting_for_trigger && exposure_active);
	endproperty
	a_excl: assert property (p_excl) else $error("waiting while exposing");
	// ==========================================
	// Register bus handshakes
	property p_bsep;
		axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready;
	endproperty
	a_bsep: assert property (p_bsep) else $error("write taken during response");
	property p_bresp;
		axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
			|-> ##[1:4] axi_rsp.bvalid;
	endproperty
	a_bresp: assert property (p_bresp) else $error("write response late");
	property p_rlat;
		axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready;
	endproperty
	a_rlat: assert property (p_rlat) else $error("read response late");
	property p_bone;
		axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid;
	endproperty
	a_bone: assert property (p_bone) else $error("write response repeated");
endmodule : ett_properties
bind ett_top ett_properties u_props (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
	.axi_rsp(axi_rsp), .external_start_trigger_input(external_start_trigger_input),
	.exposure_active(exposure_active), .overtrigger_pulse(overtrigger_pulse),
	.frame_start_pulse(frame_start_pulse), .waiting_for_trigger(waiting_for_trigger));

/* File: dv/ett_trig_src.sv */
// External start trigger source driving the input line
`timescale 1ns/1ps
module ett_trig_src (
	// Clock and command
	input wire logic aclk,
	input wire logic go,
	input wire logic fall,
	input wire logic [15:0] width,
	// Trigger line
	output logic line
);
	logic [15:0] n = 16'h0;
	// Active level held for width cycles after each go
	always_ff @(posedge aclk) begin
		if (go)
			n <= width;
		else if (n != 16'h0)
			n <= n - 16'h1;
	end
	// Idle level is the inverse of the active one
	assign line = fall ^ (n != 16'h0);
endmodule : ett_trig_src

/* File: dv/testbench.sv */
// Self-checking bench for the exposure trigger timer
`timescale 1ns/1ps
module testbench;
	import ett_pkg::*;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [1:0] p;
		logic [31:0] e;
	} ett_row_s;
	logic aclk, aresetn, go, fall, trig, exp_a, ovt, fs, wt;
	logic [15:0] width;
	logic [1:0] resp;
	logic [31:0] rv;
	ett_axi_req_s rq;
	ett_axi_rsp_s rs;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	int ov = 0;
	int t, n;
	// Write, expected response, expected read back
	ett_row_s rows [8] = '{'{8'h08, 32'h0, 2'h0, 32'h1}, '{8'h08, 32'h1000, 2'h0, 32'h1},
		'{8'h08, 32'hfff, 2'h0, 32'hfff}, '{8'h0c, 32'h0, 2'h0, 32'h14},
		'{8'h0c, 32'h989680, 2'h0, 32'h989680}, '{8'h0c, 32'h1, 2'h0, 32'h1},
		'{8'h10, 32'h3, 2'h0, 32'h3}, '{8'h20, 32'h5, 2'h2, 32'h0}};
	ett_top dut (.aclk(aclk), .aresetn(aresetn), .axi_req(rq), .axi_rsp(rs),
		.external_start_trigger_input(trig), .exposure_active(exp_a), .overtrigger_pulse(ovt),
		.frame_start_pulse(fs), .waiting_for_trigger(wt));
	ett_trig_src src (.aclk(aclk), .go(go), .fall(fall), .width(width), .line(trig));
	// ==========================================
	// Clock, watchdog and overtrigger tally
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (ovt === 1'b1)
			ov <= ov + 1;
		if (cyc == 20000) begin
			num_errors++;
			conclude();
		end
	end
	// ==========================================
	// Tasks
	task conclude;
		if (num_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// Address and data offered together, each released once taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		rq.awvalid <= 1'b1;
		rq.awaddr <= a;
		rq.wvalid <= 1'b1;
		rq.wdata <= d;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && rs.awready === 1'b1) begin
				aw = 1'b1;
				rq.awvalid <= 1'b0;
			end
			if (!w && rs.wready === 1'b1) begin
				w = 1'b1;
				rq.wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (rs.bvalid !== 1'b1);
		resp = rs.bresp;
	endtask : wr
	task rd(input logic [7:0] a);
		rq.arvalid <= 1'b1;
		rq.araddr <= a;
		do @(posedge aclk); while (rs.arready !== 1'b1);
		rq.arvalid <= 1'b0;
		do @(posedge aclk); while (rs.rvalid !== 1'b1);
		rv = rs.rdata;
	endtask : rd
	// Width zero sends no pulse, only waits for a frame start
	task shot(input logic [15:0] w, input int lim);
		if (w != 16'h0) begin
			@(posedge aclk);
			go <= 1'b1;
			width <= w;
			@(posedge aclk);
			go <= 1'b0;
		end
		t = 0;
		while (fs !== 1'b1 && t < lim) begin
			@(posedge aclk);
			t++;
		end
	endtask : shot
	// Exposure length; poke sends a second edge mid-exposure
	task wend(input logic poke);
		n = 0;
		while (exp_a === 1'b1) begin
			@(posedge aclk);
			n++;
			go <= poke && n == 50;
		end
	endtask : wend
	// ==========================================
	// Main sequence
	initial begin
		rq = '0;
		rq.wstrb = 4'hf;
		rq.bready = 1'b1;
		rq.rready = 1'b1;
		go = 1'b0;
		fall = 1'b0;
		width = 16'h0;
		aresetn = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			chk("bresp", 32'(resp), 32'(rows[i].p));
			rd(rows[i].a);
			chk("reg", rv, rows[i].e);
		end
		// Reset in mid-run restores defaults
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(8'h08);
		chk("mult", rv, 32'h1);
		rd(8'h0c);
		chk("tick", rv, 32'h14);
		// Delayed fixed exposure with overtrigger
		wr(8'h08, 32'h2);
		wr(8'h0c, 32'h28);
		wr(8'h10, 32'h3);
		shot(16'h5, 60);
		chk("idle", t, 60);
		wr(8'h04, 32'h1);
		repeat (2) @(posedge aclk);
		chk("wait", 32'(wt), 32'h1);
		shot(16'h5, 300);
		chk("dly", 32'(t >= 45 && t <= 85), 32'h1);
		wend(1'b1);
		chk("len", 32'(n >= 1970 && n <= 2030), 32'h1);
		chk("ovt", ov, 32'h1);
		rd(8'h18);
		chk("sticky", 32'(rv[3]), 32'h1);
		// Software source and free run skip the delay
		wr(8'h04, 32'h4);
		wr(8'h00, 32'h1);
		wr(8'h04, 32'h1);
		wr(8'h04, 32'h2);
		shot(16'h0, 100);
		chk("soft", 32'(t < 8), 32'h1);
		wr(8'h04, 32'h4);
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h1);
		shot(16'h0, 100);
		chk("free", 32'(t < 8), 32'h1);
		// Pulse-length exposure, auto forced off
		wr(8'h04, 32'h4);
		wr(8'h10, 32'h0);
		wr(8'h00, 32'h2b);
		rd(8'h00);
		chk("auto", rv, 32'hb);
		wr(8'h04, 32'h1);
		shot(16'h07d0, 50);
		wend(1'b0);
		chk("width", 32'(n >= 1996 && n <= 2004), 32'h1);
		chk("rate", 32'(wt), 32'h1);
		// Falling edge selection
		wr(8'h04, 32'h4);
		wr(8'h1c, 32'h2);
		wr(8'h00, 32'h17);
		fall <= 1'b1;
		wr(8'h04, 32'h1);
		shot(16'h5, 50);
		chk("fall", 32'(t < 8), 32'h1);
		wend(1'b0);
		chk("flen", 32'(n >= 1970 && n <= 2030), 32'h1);
		chk("hold", 32'(wt), 32'h0);
		conclude();
	end
endmodule : testbench
